// [logic/cic_pkg.sv]
// Constants, field layout and carrier types of the core interrupt control
// register. Assumes a 9-bit banked file address and 8-bit data path.
package cic_pkg;

  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_SRC = 3;

  // Control register mirrors, one per bank
  localparam logic [ADDR_W-1:0] CTRL_ADDR_BANK0 = 9'h00b;
  localparam logic [ADDR_W-1:0] CTRL_ADDR_BANK1 = 9'h08b;
  localparam logic [ADDR_W-1:0] CTRL_ADDR_BANK2 = 9'h10b;
  localparam logic [ADDR_W-1:0] CTRL_ADDR_BANK3 = 9'h18b;

  // Event status (clear on read) and its mask
  localparam logic [ADDR_W-1:0] EVT_STAT_ADDR = 9'h18e;
  localparam logic [ADDR_W-1:0] EVT_MASK_ADDR = 9'h18f;

  // Control register bit positions
  localparam int unsigned BIT_GLOBAL_EN = 7;
  localparam int unsigned BIT_PERIPH_EN = 6;
  localparam int unsigned BIT_TIMER0_EN = 5;
  localparam int unsigned BIT_EDGE_EN = 4;
  localparam int unsigned BIT_PORT_EN = 3;
  localparam int unsigned BIT_TIMER0_FLAG = 2;
  localparam int unsigned BIT_EDGE_FLAG = 1;
  localparam int unsigned BIT_PORT_FLAG = 0;

  // Source index inside the flag and event vectors
  localparam int unsigned SRC_PORT = 0;
  localparam int unsigned SRC_EDGE = 1;
  localparam int unsigned SRC_TIMER0 = 2;

  // Reset values
  localparam logic [DATA_W-1:0] CTRL_RST = 8'h00;
  localparam logic [DATA_W-1:0] EVT_MASK_RST = 8'h00;
  localparam logic FLAG_RST = 1'b0;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cic_bus_req_s;

  typedef struct packed {
    logic timer0_overflow;
    logic port_change;
  } cic_src_evt_s;

endpackage : cic_pkg

// [logic/cic_sticky_bit.sv]
// One flag bit that hardware sets and software loads or clears.
// Assumes set, clr and ld come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module cic_sticky_bit #(
  parameter logic RST_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic ce,
  // Control
  input  wire logic set,
  input  wire logic clr,
  input  wire logic ld,
  input  wire logic ld_val,
  // State
  output logic      q
);

  logic q_reg;

  // Set wins so an event in the clearing cycle is kept
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      q_reg <= RST_VAL;
    end else if (ce) begin
      if (set) begin
        q_reg <= 1'b1;
      end else if (ld) begin
        q_reg <= ld_val;
      end else if (clr) begin
        q_reg <= 1'b0;
      end
    end
  end

  assign q = q_reg;

endmodule : cic_sticky_bit
`default_nettype wire

// [logic/cic_edge_sync.sv]
// Synchroniser and edge detector for the external edge interrupt pin.
// Assumes the pin is asynchronous to ref_clk.
`timescale 1ns/1ps
`default_nettype none
module cic_edge_sync (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic ce,
  // Pin and polarity
  input  wire logic pin,
  input  wire logic rising_sel,
  // Result
  output logic      level,
  output logic      edge_pulse
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic filt_reg;
  logic filt_next;
  logic edge_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else if (ce) begin
      s1_reg <= pin;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Only an agreed level counts, so a metastable sample cannot fire twice
  always_comb begin
    filt_next = filt_reg;
    if (s2_reg == s3_reg) begin
      filt_next = s3_reg;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      filt_reg <= 1'b0;
      edge_reg <= 1'b0;
    end else if (ce) begin
      filt_reg <= filt_next;
      edge_reg <= (filt_next != filt_reg) && (filt_next == rising_sel);
    end
  end

  assign level = filt_reg;
  assign edge_pulse = edge_reg;

endmodule : cic_edge_sync
`default_nettype wire

// [logic/cic_ctrl.sv]
// Core interrupt control and status register with its request logic.
// Assumes the core reaches it over a strobed register port on ref_clk and
// that timer and port-change events come from logic on the same clock.
//
// Functional notes
// - Flags set regardless of any enable
// - One register mirrored at four bank addresses
// - Peripheral enable gates all peripheral requests
// - Every control bit readable and writable
// - Enables bits seven-three, flags two-zero
`timescale 1ns/1ps
`default_nettype none
module cic_ctrl
  import cic_pkg::*;
(
  // Clock, reset, enable
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  // Register port
  input  wire cic_bus_req_s bus_req,
  output logic [DATA_W-1:0] rd_data,
  // Interrupt sources
  input  wire cic_src_evt_s src_evt,
  input  wire logic         external_edge_input,
  input  wire logic         edge_rising_sel,
  input  wire logic         periph_irq_pend,
  // Core handshake
  input  wire logic         core_irq_ack,
  input  wire logic         core_irq_return,
  // Outputs
  output logic              core_irq_req,
  output logic [DATA_W-1:0] ctrl_value,
  output logic              evt_irq
);

  logic [NUM_SRC-1:0] src_set;
  logic [NUM_SRC-1:0] flag_q;
  logic [NUM_SRC-1:0] evt_q;
  logic               edge_pulse;

  logic               hit_ctrl;
  logic               hit_stat;
  logic               hit_mask;
  logic               ctrl_wr;
  logic               stat_rd;
  logic               mask_wr;

  logic               global_irq_enable_reg;
  logic               peripheral_irq_enable_reg;
  logic               timer0_overflow_irq_enable_reg;
  logic               edge_pin_irq_enable_reg;
  logic               port_change_irq_enable_reg;
  logic [NUM_SRC-1:0] evt_mask_reg;

  logic [DATA_W-1:0]  interrupt_control_reg;
  logic [DATA_W-1:0]  rd_data_reg;
  logic [DATA_W-1:0]  rd_data_next;
  logic [DATA_W-1:0]  stat_image;
  logic [DATA_W-1:0]  mask_image;
  logic               core_irq_req_reg;
  logic               core_irq_req_next;
  logic               evt_irq_reg;

  // External pin passes the synchroniser before it may set a flag
  cic_edge_sync u_edge_sync (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .ce         (ce),
    .pin        (external_edge_input),
    .rising_sel (edge_rising_sel),
    .level      (),
    .edge_pulse (edge_pulse)
  );

  // Map source strobes onto the flag index
  always_comb begin
    src_set             = '0;
    src_set[SRC_TIMER0] = src_evt.timer0_overflow;
    src_set[SRC_EDGE]   = edge_pulse;
    src_set[SRC_PORT]   = src_evt.port_change;
  end

  always_comb begin
    hit_ctrl = 1'b0;
    hit_stat = 1'b0;
    hit_mask = 1'b0;
    if (bus_req.addr == CTRL_ADDR_BANK0) begin
      hit_ctrl = 1'b1;
    end else if (bus_req.addr == CTRL_ADDR_BANK1) begin
      hit_ctrl = 1'b1;
    end else if (bus_req.addr == CTRL_ADDR_BANK2) begin
      hit_ctrl = 1'b1;
    end else if (bus_req.addr == CTRL_ADDR_BANK3) begin
      hit_ctrl = 1'b1;
    end else if (bus_req.addr == EVT_STAT_ADDR) begin
      hit_stat = 1'b1;
    end else if (bus_req.addr == EVT_MASK_ADDR) begin
      hit_mask = 1'b1;
    end
  end

  // Strobes qualified by decode; unmapped addresses fall through
  assign ctrl_wr = bus_req.wr && hit_ctrl;
  assign stat_rd = bus_req.rd && hit_stat;
  assign mask_wr = bus_req.wr && hit_mask;

  // Flags live in bits two to zero; one cell per source
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SRC; gi++) begin : g_flag
      cic_sticky_bit #(
        .RST_VAL (FLAG_RST)
      ) u_flag (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .set     (src_set[gi]),
        .clr     (1'b0),
        .ld      (ctrl_wr),
        .ld_val  (bus_req.wdata[gi]),
        .q       (flag_q[gi])
      );
      // Event status, cleared by reading it
      cic_sticky_bit #(
        .RST_VAL (FLAG_RST)
      ) u_evt (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .ce      (ce),
        .set     (src_set[gi]),
        .clr     (stat_rd),
        .ld      (1'b0),
        .ld_val  (1'b0),
        .q       (evt_q[gi])
      );
    end
  endgenerate

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      peripheral_irq_enable_reg <= CTRL_RST[BIT_PERIPH_EN];
    end else if (ce) begin
      if (ctrl_wr) begin
        peripheral_irq_enable_reg <= bus_req.wdata[BIT_PERIPH_EN];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      timer0_overflow_irq_enable_reg <= CTRL_RST[BIT_TIMER0_EN];
    end else if (ce) begin
      if (ctrl_wr) begin
        timer0_overflow_irq_enable_reg <= bus_req.wdata[BIT_TIMER0_EN];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_pin_irq_enable_reg <= CTRL_RST[BIT_EDGE_EN];
    end else if (ce) begin
      if (ctrl_wr) begin
        edge_pin_irq_enable_reg <= bus_req.wdata[BIT_EDGE_EN];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      port_change_irq_enable_reg <= CTRL_RST[BIT_PORT_EN];
    end else if (ce) begin
      if (ctrl_wr) begin
        port_change_irq_enable_reg <= bus_req.wdata[BIT_PORT_EN];
      end
    end
  end

  // Core acknowledge drops the global enable to block nesting; it wins
  // over a software write in the same cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      global_irq_enable_reg <= CTRL_RST[BIT_GLOBAL_EN];
    end else if (ce) begin
      if (core_irq_ack) begin
        global_irq_enable_reg <= 1'b0;
      end else if (core_irq_return) begin
        global_irq_enable_reg <= 1'b1;
      end else if (ctrl_wr) begin
        global_irq_enable_reg <= bus_req.wdata[BIT_GLOBAL_EN];
      end
    end
  end

  // Mask gates only the status interrupt, never the core request
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_mask_reg <= EVT_MASK_RST[NUM_SRC-1:0];
    end else if (ce) begin
      if (mask_wr) begin
        evt_mask_reg <= bus_req.wdata[NUM_SRC-1:0];
      end
    end
  end

  // Image of the register as software sees it
  always_comb begin
    interrupt_control_reg                  = '0;
    interrupt_control_reg[BIT_GLOBAL_EN]   = global_irq_enable_reg;
    interrupt_control_reg[BIT_PERIPH_EN]   = peripheral_irq_enable_reg;
    interrupt_control_reg[BIT_TIMER0_EN]   = timer0_overflow_irq_enable_reg;
    interrupt_control_reg[BIT_EDGE_EN]     = edge_pin_irq_enable_reg;
    interrupt_control_reg[BIT_PORT_EN]     = port_change_irq_enable_reg;
    interrupt_control_reg[BIT_TIMER0_FLAG] = flag_q[SRC_TIMER0];
    interrupt_control_reg[BIT_EDGE_FLAG]   = flag_q[SRC_EDGE];
    interrupt_control_reg[BIT_PORT_FLAG]   = flag_q[SRC_PORT];
  end

  // Status and mask sit in the low bits; upper bits read 0
  always_comb begin
    stat_image              = '0;
    mask_image              = '0;
    stat_image[NUM_SRC-1:0] = evt_q;
    mask_image[NUM_SRC-1:0] = evt_mask_reg;
  end

  always_comb begin
    rd_data_next = '0;
    if (bus_req.rd) begin
      if (hit_ctrl) begin
        rd_data_next = interrupt_control_reg;
      end else if (hit_stat) begin
        rd_data_next = stat_image;
      end else if (hit_mask) begin
        rd_data_next = mask_image;
      end
    end
  end

  // Read data stand for one cycle only, zero otherwise
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_reg <= '0;
    end else if (ce) begin
      rd_data_reg <= rd_data_next;
    end
  end

  always_comb begin
    core_irq_req_next = 1'b0;
    if (global_irq_enable_reg) begin
      if (timer0_overflow_irq_enable_reg && flag_q[SRC_TIMER0]) begin
        core_irq_req_next = 1'b1;
      end
      if (edge_pin_irq_enable_reg && flag_q[SRC_EDGE]) begin
        core_irq_req_next = 1'b1;
      end
      if (port_change_irq_enable_reg && flag_q[SRC_PORT]) begin
        core_irq_req_next = 1'b1;
      end
      if (peripheral_irq_enable_reg && periph_irq_pend) begin
        core_irq_req_next = 1'b1;
      end
    end
  end

  // Registered so the core sees a glitch-free level; costs one cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_irq_req_reg <= 1'b0;
    end else if (ce) begin
      core_irq_req_reg <= core_irq_req_next;
    end
  end

  // Status interrupt trails the status bits by one cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_irq_reg <= 1'b0;
    end else if (ce) begin
      evt_irq_reg <= |(evt_q & evt_mask_reg);
    end
  end

  assign rd_data      = rd_data_reg;
  assign ctrl_value   = interrupt_control_reg;
  assign core_irq_req = core_irq_req_reg;
  assign evt_irq      = evt_irq_reg;

endmodule : cic_ctrl
`default_nettype wire

// [verif/cic_ctrl_checker.sv]
// Port assertions for the core interrupt control register.
// Assumes one clock domain and the bank map of the package.
`timescale 1ns/1ps
`default_nettype none
module cic_ctrl_checker
  import cic_pkg::*;
(
  // Clock and reset
  input wire logic              ref_clk,
  input wire logic              rst_n,
  input wire logic              ce,
  // Register port
  input wire cic_bus_req_s      bus_req,
  input wire logic [DATA_W-1:0] rd_data,
  // Sources and core
  input wire cic_src_evt_s      src_evt,
  input wire logic              periph_irq_pend,
  input wire logic              core_irq_ack,
  input wire logic              core_irq_return,
  input wire logic              core_irq_req,
  input wire logic [DATA_W-1:0] ctrl_value
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic mirror;
  logic mapped;
  logic cause;
  logic [7:0] c;
  assign c = ctrl_value;
  // Low seven address bits select the control register in every bank
  assign mirror = bus_req.addr[6:0] == 7'h0b;
  assign mapped = mirror || bus_req.addr == EVT_STAT_ADDR
                  || bus_req.addr == EVT_MASK_ADDR;
  assign cause = c[7] & ((c[5] & c[2]) | (c[4] & c[1]) | (c[3] & c[0])
                 | (c[6] & periph_irq_pend));
  sequence s_timer_evt; ce && src_evt.timer0_overflow; endsequence
  sequence s_armed; ce && c[7] && c[5] && c[2]; endsequence
  property p_timer_flag; s_timer_evt |=> c[BIT_TIMER0_FLAG]; endproperty
  a_timer_flag: assert property (p_timer_flag)
    else $error("timer flag not set");
  property p_port_flag; ce && src_evt.port_change |=> c[BIT_PORT_FLAG];
  endproperty
  a_port_flag: assert property (p_port_flag)
    else $error("port flag not set");
  property p_req; ce |=> core_irq_req == $past(cause); endproperty
  a_req: assert property (p_req)
    else $error("request differs from enables and flags");
  property p_timer_req; s_timer_evt ##1 s_armed |=> core_irq_req;
  endproperty
  a_timer_req: assert property (p_timer_req)
    else $error("timer event raised no request");
  property p_rd_ctrl; ce && bus_req.rd && mirror |=> rd_data == $past(c);
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl)
    else $error("mirror read wrong");
  property p_rd_idle; ce && !bus_req.rd |=> rd_data == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read cycle");
  property p_unmapped; ce && bus_req.rd && !mapped |=> rd_data == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_wr_ctrl;
    ce && bus_req.wr && mirror && !core_irq_ack && !core_irq_return
    |=> c[7:3] == $past(bus_req.wdata[7:3]);
  endproperty
  a_wr_ctrl: assert property (p_wr_ctrl)
    else $error("enable write lost");
  property p_ack; ce && core_irq_ack |=> !c[BIT_GLOBAL_EN]; endproperty
  a_ack: assert property (p_ack)
    else $error("ack left global enable set");
endmodule : cic_ctrl_checker
bind cic_ctrl cic_ctrl_checker chk_u (
  .ref_clk(ref_clk), .rst_n(rst_n), .ce(ce), .bus_req(bus_req),
  .rd_data(rd_data), .src_evt(src_evt), .periph_irq_pend(periph_irq_pend),
  .core_irq_ack(core_irq_ack), .core_irq_return(core_irq_return),
  .core_irq_req(core_irq_req), .ctrl_value(ctrl_value)
);
`default_nettype wire

// [verif/cic_src_model.sv]
// Model of the timer, port-change and edge-pin sources.
// Assumes kick commands from the bench on ref_clk.
`timescale 1ns/1ps
`default_nettype none
module cic_src_model
  import cic_pkg::*;
(
  // Clock and reset
  input  wire logic       ref_clk,
  input  wire logic       rst_n,
  // Commands: timer, port, pin
  input  wire logic [2:0] kick,
  // Source lines
  output var cic_src_evt_s src_evt,
  output logic            pin
);
  // Overflow and mismatch both last while kicked; the pin toggles per kicked cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      src_evt <= '0;
      pin     <= 1'b0;
    end else begin
      src_evt.timer0_overflow <= kick[0];
      src_evt.port_change     <= kick[1];
      pin                     <= pin ^ kick[2];
    end
  end
endmodule : cic_src_model
`default_nettype wire

// [verif/cic_ctrl_bench.sv]
// Self-checking bench for the core interrupt control register.
// Assumes the source model and checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module cic_ctrl_bench
  import cic_pkg::*;
;
  logic ref_clk, rst_n, ce, sel, pend, ack, ret, pin, req, evt_irq;
  logic [2:0] kick;
  logic [7:0] rd_data, ctrl_value, d;
  logic [31:0] seed, r;
  cic_bus_req_s bus_req;
  cic_src_evt_s src_evt;
  int n_mismatch, samples_checked;
  logic [8:0] mir [4] = '{CTRL_ADDR_BANK0, CTRL_ADDR_BANK1,
                         CTRL_ADDR_BANK2, CTRL_ADDR_BANK3};
  cic_src_model src_u (.ref_clk(ref_clk), .rst_n(rst_n), .kick(kick),
    .src_evt(src_evt), .pin(pin));
  cic_ctrl dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .ce(ce),
    .bus_req(bus_req), .rd_data(rd_data), .src_evt(src_evt),
    .external_edge_input(pin), .edge_rising_sel(sel),
    .periph_irq_pend(pend), .core_irq_ack(ack), .core_irq_return(ret),
    .core_irq_req(req), .ctrl_value(ctrl_value), .evt_irq(evt_irq));
  always #20 ref_clk = ~ref_clk;
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  function automatic logic req_fn(logic [7:0] c, logic p);
    return c[7] & ((c[5] & c[2]) | (c[4] & c[1]) | (c[3] & c[0]) | (c[6] & p));
  endfunction : req_fn
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic wr(input logic [8:0] a, input logic [7:0] v);
    @(posedge ref_clk);
    bus_req <= '{1'b1, 1'b0, a, v};
    @(posedge ref_clk);
    bus_req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [8:0] a, output logic [7:0] v);
    @(posedge ref_clk);
    bus_req.rd   <= 1'b1;
    bus_req.addr <= a;
    @(posedge ref_clk);
    bus_req.rd <= 1'b0;
    // Data launched at the strobe edge, taken before the next update
    @(posedge ref_clk);
    v = rd_data;
  endtask : rd
  // Pin needs four edges to pass the synchroniser; its flag sets on the fifth
  task automatic fire(input logic [2:0] k);
    @(posedge ref_clk);
    kick <= k;
    @(posedge ref_clk);
    kick <= 3'b000;
    repeat (6) @(posedge ref_clk);
  endtask : fire
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : conclude
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    conclude();
  end
  initial begin
    {ref_clk, rst_n, pend, ack, ret, kick, bus_req} = '0;
    {ce, sel} = 2'b11;
    seed = 32'he866e3f9;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    foreach (mir[i]) begin
      rd(mir[i], d);
      check(d, CTRL_RST);
    end
    $display("reset test done");
    repeat (40) begin
      r = xs();
      pend <= r[8];
      wr(mir[r[10:9]], r[7:0]);
      rd(mir[r[12:11]], d);
      check(d, r[7:0]);
      check({7'h00, req}, {7'h00, req_fn(r[7:0], r[8])});
    end
    $display("mirror test done");
    wr(CTRL_ADDR_BANK0, 8'h00);
    rd(EVT_STAT_ADDR, d);
    fire(3'b111);
    rd(CTRL_ADDR_BANK1, d);
    check(d, 8'h07);
    check({7'h00, req}, 8'h00);
    wr(CTRL_ADDR_BANK2, 8'h00);
    sel <= 1'b0;
    fire(3'b100);
    rd(CTRL_ADDR_BANK3, d);
    check(d, 8'h02);
    wr(EVT_MASK_ADDR, 8'h04);
    rd(EVT_MASK_ADDR, d);
    check(d, 8'h04);
    check({7'h00, evt_irq}, 8'h01);
    rd(EVT_STAT_ADDR, d);
    check(d, 8'h07);
    // Clear lands at the read edge, the interrupt one edge later
    @(posedge ref_clk);
    check({7'h00, evt_irq}, 8'h00);
    $display("flag test done");
    // Flags cleared before the enables go on
    wr(CTRL_ADDR_BANK0, 8'h00);
    wr(CTRL_ADDR_BANK0, 8'ha0);
    fire(3'b001);
    check({7'h00, req}, 8'h01);
    @(posedge ref_clk);
    ack <= 1'b1;
    @(posedge ref_clk);
    ack <= 1'b0;
    rd(CTRL_ADDR_BANK1, d);
    check(d, 8'h24);
    ret <= 1'b1;
    @(posedge ref_clk);
    ret <= 1'b0;
    wr(9'h00c, 8'hff);
    rd(9'h00c, d);
    check(d, 8'h00);
    ce <= 1'b0;
    wr(CTRL_ADDR_BANK0, 8'h55);
    ce <= 1'b1;
    rd(CTRL_ADDR_BANK2, d);
    check(d, 8'ha4);
    $display("request test done");
    // Mid-run reset returns every output to its reset level
    rst_n <= 1'b0;
    @(posedge ref_clk);
    check(ctrl_value, CTRL_RST);
    check({7'h00, req}, 8'h00);
    check({7'h00, evt_irq}, 8'h00);
    rst_n <= 1'b1;
    rd(CTRL_ADDR_BANK3, d);
    check(d, CTRL_RST);
    $display("reset rerun done");
    conclude();
  end
endmodule : cic_ctrl_bench
`default_nettype wire
